/* design/eua_defs.vh */
// Purpose: Shared constants of the enhanced serial port.
// Assumes: Byte addresses on a 32-bit AHB-Lite bus, one register a word.
// Notes:   Flag bits of the control register sit in the low byte.
`ifndef EUA_DEFS_VH
`define EUA_DEFS_VH

`define EUA_OFS_CTL      8'h00
`define EUA_OFS_BUF      8'h04
`define EUA_OFS_SLAVE_ADDRESS    8'h08
`define EUA_OFS_SMASK    8'h0C
`define EUA_OFS_POWER_CONTROL     8'h10
`define EUA_OFS_BAUD     8'h14
`define EUA_OFS_NONE     8'hFF

`define EUA_CTL_MODE_HI  7
`define EUA_CTL_MODE_LO  6
`define EUA_CTL_MPCE     5
`define EUA_CTL_REN      4
`define EUA_CTL_TB8      3
`define EUA_CTL_RB8      2
`define EUA_CTL_TXDONE   1
`define EUA_CTL_RXDONE   0
`define EUA_POWER_CONTROL_FCS     6

`define EUA_MODE_SHIFT   2'h0
`define EUA_MODE_ASYNC8  2'h1
`define EUA_MODE_FIX9    2'h2
`define EUA_MODE_VAR9    2'h3

`define EUA_BAUD_RST     16'h0036
`define EUA_TICK_LAST    4'hF
`define EUA_TICK_MID     4'h7

`endif

/* design/eua_shift.v */
// Purpose: Transmit engine for the frame modes plus the mode 0 shifter.
// Assumes: One tick is one sixteenth of a bit period.
// Notes:   A start while busy is ignored here, not left to the caller.
`timescale 1ns/100ps
`include "eua_defs.vh"
module eua_shift
(
    // Clock and reset
    input  wire       i_clk,
    input  wire       i_rst_n,
    // Control
    input  wire       i_tick,
    input  wire [1:0] i_mode,
    input  wire       i_tx_go,
    input  wire       i_m0_rx_go,
    input  wire [7:0] i_data,
    input  wire       i_tb8,
    input  wire       i_rxd,
    // Status
    output reg        o_busy,
    output reg        o_tx_done,
    output reg        o_m0_done,
    output wire [7:0] o_m0_data,
    // Pins
    output reg        o_txd,
    output reg        o_rxd_out,
    output reg        o_rxd_oe
);
    reg [10:0] sh;
    reg [3:0]  nbits;
    reg [3:0]  tcnt;
    reg        m0;
    reg        m0rx;

    assign o_m0_data = sh[7:0];

    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sh <= 11'h7FF;
            nbits <= 4'h0;
            tcnt <= 4'h0;
            m0 <= 1'b0;
            m0rx <= 1'b0;
            o_busy <= 1'b0;
            o_tx_done <= 1'b0;
            o_m0_done <= 1'b0;
            o_txd <= 1'b1;
            o_rxd_out <= 1'b1;
            o_rxd_oe <= 1'b0;
        end
        else
        begin
            o_tx_done <= 1'b0;
            o_m0_done <= 1'b0;
            if (!o_busy && (i_tx_go || i_m0_rx_go))
            begin
                o_busy <= 1'b1;
                tcnt <= 4'h0;
                m0 <= (i_mode == `EUA_MODE_SHIFT);
                m0rx <= !i_tx_go;
                o_rxd_oe <= (i_mode == `EUA_MODE_SHIFT) && i_tx_go;
                if (i_mode == `EUA_MODE_SHIFT)
                begin
                    sh <= {3'h7, i_data};
                    nbits <= 4'h8;
                end
                else if (i_mode[1])
                begin
                    sh <= {1'b1, i_tb8, i_data, 1'b0};
                    nbits <= 4'hB;
                end
                else
                begin
                    sh <= {2'h3, i_data, 1'b0};
                    nbits <= 4'hA;
                end
            end
            else if (o_busy && i_tick)
            begin
                tcnt <= tcnt + 4'h1;
                if (tcnt == `EUA_TICK_LAST)
                begin
                    nbits <= nbits - 4'h1;
                    if (m0 && m0rx)
                        sh <= {3'h7, i_rxd, sh[7:1]};
                    else if (!(m0 && nbits == 4'h1))
                        sh <= {1'b1, sh[10:1]};
                    if (nbits == 4'h1)
                    begin
                        o_busy <= 1'b0;
                        o_rxd_oe <= 1'b0;
                        o_tx_done <= !m0rx;
                        o_m0_done <= m0rx;
                    end
                end
            end
            // In mode 0 the transmit pin carries the shift clock.
            o_txd <= (o_busy && m0) ? tcnt[3] : (o_busy ? sh[0] : 1'b1);
            o_rxd_out <= (o_busy && m0 && !m0rx) ? sh[0] : 1'b1;
        end
    end
endmodule

/* design/eua_recv.v */
// Purpose: Receiver for the asynchronous modes 1, 2 and 3.
// Assumes: Line input already synchronised; sixteen ticks a bit.
// Notes:   A start bit that is high again at mid-bit is a glitch.
`timescale 1ns/100ps
`include "eua_defs.vh"
module eua_recv
(
    // Clock and reset
    input  wire       i_clk,
    input  wire       i_rst_n,
    // Control
    input  wire       i_tick,
    input  wire       i_en,
    input  wire       i_nine,
    input  wire       i_rxd,
    // Results
    output reg        o_data_evt,
    output reg        o_stop_evt,
    output reg        o_stop,
    output wire [7:0] o_data,
    output wire       o_bit9
);
    reg [8:0] sh;
    reg [3:0] tcnt;
    reg [3:0] bitn;
    reg       busy;
    reg       prev;
    wire [3:0] last_data = i_nine ? 4'h9 : 4'h8;

    assign o_data = i_nine ? sh[7:0] : sh[8:1];
    assign o_bit9 = i_nine ? sh[8] : o_stop;

    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sh <= 9'h000;
            tcnt <= 4'h0;
            bitn <= 4'h0;
            busy <= 1'b0;
            prev <= 1'b1;
            o_data_evt <= 1'b0;
            o_stop_evt <= 1'b0;
            o_stop <= 1'b1;
        end
        else
        begin
            prev <= i_rxd;
            o_data_evt <= 1'b0;
            o_stop_evt <= 1'b0;
            if (!busy && i_en && prev && !i_rxd)
            begin
                busy <= 1'b1;
                tcnt <= 4'h0;
                bitn <= 4'h0;
            end
            else if (busy && i_tick)
            begin
                tcnt <= tcnt + 4'h1;
                if (tcnt == `EUA_TICK_MID)
                begin
                    bitn <= bitn + 4'h1;
                    if (bitn == 4'h0)
                        busy <= !i_rxd;
                    else if (bitn <= last_data)
                    begin
                        sh <= {i_rxd, sh[8:1]};
                        o_data_evt <= (bitn == last_data);
                    end
                    else
                    begin
                        o_stop <= i_rxd;
                        o_stop_evt <= 1'b1;
                        busy <= 1'b0;
                    end
                end
            end
        end
    end
endmodule

/* design/eua_top.v */
// Purpose: Full-duplex serial port with framing check and address match.
// Assumes: AHB-Lite single word transfers; I_RXD is asynchronous.
// Notes:   Reads take one wait state, writes none.
//
// The address map and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
`include "eua_defs.vh"
module eua_top
(
    // Clock and reset
    input  wire        I_SYS_CLK,
    input  wire        I_RST_N,
    // AHB-Lite slave
    input  wire        I_HSEL,
    input  wire [31:0] I_HADDR,
    input  wire [1:0]  I_HTRANS,
    input  wire        I_HWRITE,
    input  wire [2:0]  I_HSIZE,
    input  wire        I_HREADY,
    input  wire [31:0] I_HWDATA,
    output reg  [31:0] O_HRDATA,
    output reg         O_HREADYOUT,
    output reg         O_HRESP,
    // Serial pins
    input  wire        I_RXD,
    output wire        O_RXD_OUT,
    output wire        O_RXD_OE,
    output wire        O_TXD
);
    reg [1:0]  mode;
    reg        mpce;
    reg        ren;
    reg        tb8;
    reg        rb8;
    reg        tx_done;
    reg        rx_done;
    reg        fe;
    reg        fcs;
    reg [7:0]  rbuf;
    reg [7:0]  tbuf;
    reg [7:0]  slave_address;
    reg [7:0]  smask;
    reg [15:0] baud;
    reg [15:0] baud_cnt;
    reg        tick;
    reg        rxd_m;
    reg        rxd_s;
    reg        wr_pend;
    reg        rd_pend;
    reg [7:0]  wr_addr;
    reg [7:0]  rd_addr;

    wire       addr_ph;
    wire       wr_ctl;
    wire       wr_buf;
    wire       busy;
    wire       tx_evt;
    wire       m0_evt;
    wire [7:0] m0_data;
    wire       data_evt;
    wire       stop_evt;
    wire       stop_bit;
    wire [7:0] rx_data;
    wire       rx_bit9;
    wire       is_m0;
    wire       mp_on;
    wire       use_stop;
    wire       frame_evt;
    wire       accept;
    wire       fe_set;
    wire       m0_rx_go;

    // Given address and broadcast address checks.
    function addr_hit;
        input [7:0] rx;
        input [7:0] sa;
        input [7:0] mk;
        reg   [7:0] bc;
        begin
            bc = sa | mk;
            addr_hit = (((rx ^ sa) & mk) == 8'h00) || ((rx & bc) == bc);
        end
    endfunction

    function [31:0] word8;
        input [7:0] v;
        begin
            word8 = {24'h000000, v};
        end
    endfunction

    assign addr_ph = I_HSEL && I_HTRANS[1] && I_HREADY;
    assign wr_ctl = wr_pend && (wr_addr == `EUA_OFS_CTL);
    assign wr_buf = wr_pend && (wr_addr == `EUA_OFS_BUF);
    assign is_m0 = (mode == `EUA_MODE_SHIFT);
    assign mp_on = mpce && !is_m0;
    assign use_stop = fcs || (mpce && (mode == `EUA_MODE_ASYNC8));
    assign frame_evt = use_stop ? stop_evt : data_evt;
    assign accept = frame_evt && !rx_done && (!mp_on || rx_bit9) &&
                    (!mp_on || addr_hit(rx_data, slave_address, smask));
    assign fe_set = stop_evt && fcs && !stop_bit;
    assign m0_rx_go = is_m0 && ren && !rx_done && !busy && !wr_buf;

    // Two-stage synchroniser for the receive pin.
    always @(posedge I_SYS_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            rxd_m <= 1'b1;
            rxd_s <= 1'b1;
        end
        else
        begin
            rxd_m <= I_RXD;
            rxd_s <= rxd_m;
        end
    end

    // The divisor gives sixteen ticks a bit; zero stops the port.
    always @(posedge I_SYS_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            baud_cnt <= 16'h0000;
            tick <= 1'b0;
        end
        else if (baud_cnt >= baud)
        begin
            baud_cnt <= 16'h0000;
            tick <= (baud != 16'h0000);
        end
        else
        begin
            baud_cnt <= baud_cnt + 16'h0001;
            tick <= 1'b0;
        end
    end

    // Bus address phase capture and response.
    always @(posedge I_SYS_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            wr_addr <= 8'h00;
            rd_addr <= 8'h00;
            O_HREADYOUT <= 1'b1;
            O_HRESP <= 1'b0;
            O_HRDATA <= 32'h00000000;
        end
        else
        begin
            wr_pend <= addr_ph && I_HWRITE;
            rd_pend <= addr_ph && !I_HWRITE;
            if (addr_ph)
            begin
                // Upper address bits are checked here, while the address phase stands.
                wr_addr <= (I_HADDR[31:8] == 24'h000000) ? {I_HADDR[7:2], 2'h0} : `EUA_OFS_NONE;
                rd_addr <= (I_HADDR[31:8] == 24'h000000) ? {I_HADDR[7:2], 2'h0} : `EUA_OFS_NONE;
            end
            // Reads wait one cycle so a write just before is visible.
            O_HREADYOUT <= !(addr_ph && !I_HWRITE);
            if (rd_pend)
            begin
                if (rd_addr == `EUA_OFS_CTL)
                    O_HRDATA <= word8({fcs ? fe : mode[1], mode[0], mpce, ren,
                                       tb8, rb8, tx_done, rx_done});
                else if (rd_addr == `EUA_OFS_BUF)
                    O_HRDATA <= word8(rbuf);
                else if (rd_addr == `EUA_OFS_SLAVE_ADDRESS)
                    O_HRDATA <= word8(slave_address);
                else if (rd_addr == `EUA_OFS_SMASK)
                    O_HRDATA <= word8(smask);
                else if (rd_addr == `EUA_OFS_POWER_CONTROL)
                    O_HRDATA <= word8({1'b0, fcs, 6'h00});
                else if (rd_addr == `EUA_OFS_BAUD)
                    O_HRDATA <= {16'h0000, baud};
                else
                    O_HRDATA <= 32'h00000000;
            end
        end
    end

    // Software-written configuration.
    always @(posedge I_SYS_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            mode <= `EUA_MODE_SHIFT;
            mpce <= 1'b0;
            ren <= 1'b0;
            tb8 <= 1'b0;
            fcs <= 1'b0;
            tbuf <= 8'h00;
            slave_address <= 8'h00;
            smask <= 8'h00;
            baud <= `EUA_BAUD_RST;
        end
        else if (wr_pend)
        begin
            if (wr_addr == `EUA_OFS_CTL)
            begin
                // mode select
                // While the check is selected, bit 7 addresses the error flag.
                if (!fcs)
                    mode[1] <= I_HWDATA[`EUA_CTL_MODE_HI];
                mode[0] <= I_HWDATA[`EUA_CTL_MODE_LO];
                mpce <= I_HWDATA[`EUA_CTL_MPCE];
                ren <= I_HWDATA[`EUA_CTL_REN];
                tb8 <= I_HWDATA[`EUA_CTL_TB8];
            end
            else if (wr_addr == `EUA_OFS_BUF)
                tbuf <= I_HWDATA[7:0];
            else if (wr_addr == `EUA_OFS_SLAVE_ADDRESS)
                slave_address <= I_HWDATA[7:0];
            else if (wr_addr == `EUA_OFS_SMASK)
                smask <= I_HWDATA[7:0];
            else if (wr_addr == `EUA_OFS_POWER_CONTROL)
                fcs <= I_HWDATA[`EUA_POWER_CONTROL_FCS];
            else if (wr_addr == `EUA_OFS_BAUD)
                baud <= I_HWDATA[15:0];
        end
    end

    // Flags: a hardware set in the same cycle as a clear wins.
    always @(posedge I_SYS_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            rx_done <= 1'b0;
            tx_done <= 1'b0;
            fe <= 1'b0;
            rb8 <= 1'b0;
            rbuf <= 8'h00;
        end
        else
        begin
            tx_done <= tx_evt || (wr_ctl ? I_HWDATA[`EUA_CTL_TXDONE] : tx_done);
            rx_done <= accept || m0_evt ||
                       (wr_ctl ? I_HWDATA[`EUA_CTL_RXDONE] : rx_done);
            fe <= fe_set || ((wr_ctl && fcs) ? I_HWDATA[`EUA_CTL_MODE_HI] : fe);
            if (accept)
            begin
                rbuf <= rx_data;
                rb8 <= rx_bit9;
            end
            else if (m0_evt)
                rbuf <= m0_data;
            else if (wr_ctl)
                rb8 <= I_HWDATA[`EUA_CTL_RB8];
        end
    end

    eua_shift u_shift
    (
        .i_clk      (I_SYS_CLK),
        .i_rst_n    (I_RST_N),
        .i_tick     (tick),
        .i_mode     (mode),
        .i_tx_go    (wr_buf),
        .i_m0_rx_go (m0_rx_go),
        .i_data     (I_HWDATA[7:0]),
        .i_tb8      (tb8),
        .i_rxd      (rxd_s),
        .o_busy     (busy),
        .o_tx_done  (tx_evt),
        .o_m0_done  (m0_evt),
        .o_m0_data  (m0_data),
        .o_txd      (O_TXD),
        .o_rxd_out  (O_RXD_OUT),
        .o_rxd_oe   (O_RXD_OE)
    );

    eua_recv u_recv
    (
        .i_clk      (I_SYS_CLK),
        .i_rst_n    (I_RST_N),
        .i_tick     (tick),
        .i_en       (ren && !is_m0),
        .i_nine     (mode[1]),
        .i_rxd      (rxd_s),
        .o_data_evt (data_evt),
        .o_stop_evt (stop_evt),
        .o_stop     (stop_bit),
        .o_data     (rx_data),
        .o_bit9     (rx_bit9)
    );
endmodule

/* verification/eua_peer.sv */
// Purpose: Far-side serial controller that drives the receive line and watches transmit.
// Assumes: One bit lasts BIT_CLKS system clocks; the line idles high.
// Notes:   Captures 8-bit frames only, which covers mode 1 transmit.
`timescale 1ns/100ps
module eua_peer
#(
    parameter BIT_CLKS = 32
)
(
    // Clock and line
    input  wire       i_clk,
    input  wire       i_txd,
    output reg        o_line,
    // Captured transmit data
    output reg  [7:0] o_got,
    output reg  [7:0] o_cnt
);
    integer i;
    initial
    begin
        o_line = 1'b1;
        o_got = 8'h00;
        o_cnt = 8'h00;
    end
    always
    begin
        @(negedge i_txd);
        repeat (BIT_CLKS / 2) @(posedge i_clk);
        for (i = 0; i < 8; i = i + 1)
        begin
            repeat (BIT_CLKS) @(posedge i_clk);
            o_got = {i_txd, o_got[7:1]};
        end
        wait (i_txd);
        o_cnt = o_cnt + 8'h01;
    end
    // start, LSB first, ninth bit, stop
    task send(input [7:0] d, input nine, input b9, input stp);
        reg     [10:0] f;
        integer        n;
        begin
            f = nine ? {stp, b9, d, 1'b0} : {1'b1, stp, d, 1'b0};
            for (n = 0; n < (nine ? 11 : 10); n = n + 1)
            begin
                o_line <= f[n];
                repeat (BIT_CLKS) @(posedge i_clk);
            end
            // The released line returns to its idle high level for one bit.
            o_line <= 1'b1;
            repeat (BIT_CLKS) @(posedge i_clk);
        end
    endtask
endmodule

/* verification/eua_top_sva.sv */
// Purpose: Port-level checks of the bus slave and serial pins.
// Assumes: Single clock domain, active-low asynchronous reset.
// Notes:   Bit timing depends on a register, so only minimum widths are checked.
`timescale 1ns/100ps
module eua_chk
(
    input wire        I_SYS_CLK,
    input wire        I_RST_N,
    input wire        I_HSEL,
    input wire [1:0]  I_HTRANS,
    input wire        I_HWRITE,
    input wire        I_HREADY,
    input wire [31:0] O_HRDATA,
    input wire        O_HREADYOUT,
    input wire        O_HRESP,
    input wire        O_RXD_OUT,
    input wire        O_RXD_OE,
    input wire        O_TXD
);
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RST_N);
    sequence s_rd;
        I_HSEL && I_HTRANS[1] && I_HREADY && !I_HWRITE;
    endsequence
    sequence s_wr;
        I_HSEL && I_HTRANS[1] && I_HREADY && I_HWRITE;
    endsequence
    sequence s_rd_end;
        !O_HREADYOUT ##1 O_HREADYOUT;
    endsequence
    a_resp_okay: assert property (O_HRESP == 1'b0) else $error("response not okay");
    a_read_wait: assert property (s_rd |=> s_rd_end) else $error("read wait state wrong");
    a_write_nowait: assert property (s_wr |=> O_HREADYOUT) else $error("write stalled");
    a_wait_single: assert property (!O_HREADYOUT |=> O_HREADYOUT) else $error("long stall");
    a_rdata_hold: assert property (!$stable(O_HRDATA) |-> O_HREADYOUT && !$past(O_HREADYOUT))
        else $error("read data moved outside a read");
    a_rdata_upper: assert property (O_HREADYOUT && !$past(O_HREADYOUT) |->
        O_HRDATA[31:8] == 24'h0) else $error("upper read bits set");
    a_line_low_min: assert property ($fell(O_TXD) |-> !O_TXD [*8])
        else $error("transmit low too short");
    a_reset_idle: assert property ($rose(I_RST_N) |-> O_TXD && O_RXD_OUT && !O_RXD_OE
        && O_HREADYOUT && O_HRDATA == 32'h0) else $error("pins not idle after reset");
endmodule
bind eua_top eua_chk u_eua_chk
(
    .I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N), .I_HSEL(I_HSEL), .I_HTRANS(I_HTRANS),
    .I_HWRITE(I_HWRITE), .I_HREADY(I_HREADY), .O_HRDATA(O_HRDATA),
    .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP), .O_RXD_OUT(O_RXD_OUT),
    .O_RXD_OE(O_RXD_OE), .O_TXD(O_TXD)
);

/* verification/tb_eua_top.sv */
// Purpose: Self-checking bench for the serial port over its register bus.
// Assumes: Baud divisor 1, so one bit is 32 clocks.
// Notes:   Mode 0 runs last, since the peer reads its shift clock as frames.
`timescale 1ns/100ps
`include "eua_defs.vh"
`define CHK(nm, e, g) begin checks = checks + 1; if ((e) !== (g)) begin \
    errors = errors + 1; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_eua_top;
    localparam BIT = 16 * 2;
    reg         clk;
    reg         rst_n;
    reg         hsel;
    reg  [31:0] haddr;
    reg  [1:0]  htrans;
    reg         hwrite;
    reg  [2:0]  hsize;
    reg  [31:0] hwdata;
    wire [31:0] hrdata;
    wire        hreadyout;
    wire        hresp;
    wire        rxd;
    wire        rxd_out;
    wire        rxd_oe;
    wire        txd;
    wire [7:0]  got;
    wire [7:0]  cnt;
    integer     errors;
    integer     checks;
    integer     i;
    integer     n;
    reg  [31:0] d;
    reg  [31:0] seed;
    reg  [31:0] ctl_v;
    reg  [7:0]  c;
    reg  [7:0]  a;
    reg  [7:0]  m0_sh;
    eua_top u_eua_top (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HREADY(hreadyout),
        .I_HWDATA(hwdata), .O_HRDATA(hrdata), .O_HREADYOUT(hreadyout), .O_HRESP(hresp),
        .I_RXD(rxd), .O_RXD_OUT(rxd_out), .O_RXD_OE(rxd_oe), .O_TXD(txd));
    eua_peer #(.BIT_CLKS(BIT)) u_eua_peer (.i_clk(clk), .i_txd(txd), .o_line(rxd),
        .o_got(got), .o_cnt(cnt));
    // Mode 0 data is settled at each rising edge of the shift clock.
    always @(posedge txd)
        m0_sh <= {rxd_out, m0_sh[7:1]};
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function hit(input [7:0] rx, input [7:0] sa, input [7:0] mk);
        hit = (((rx ^ sa) & mk) == 8'h00) || ((rx & (sa | mk)) == (sa | mk));
    endfunction
    task test_done;
        begin
            if (errors == 0 && checks > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // Ready is stable mid-cycle, so the falling edge shows what the next edge samples.
    task wait_rdy;
        reg r;
        integer k;
        begin
            r = 1'b0;
            for (k = 0; r !== 1'b1; k = k + 1)
            begin
                @(negedge clk);
                r = hreadyout;
                d = hrdata;
                @(posedge clk);
                if (k > 50)
                begin
                    errors = errors + 1;
                    test_done;
                end
            end
        end
    endtask
    task xfer(input [31:0] ad, input w, input [31:0] wd);
        begin
            @(posedge clk);
            hsel <= 1'b1;
            haddr <= ad;
            htrans <= 2'h2;
            hwrite <= w;
            wait_rdy;
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= wd;
            wait_rdy;
        end
    endtask
    task rx_check(input [7:0] b, input nine, input b9, input stp, input exp);
        begin
            u_eua_peer.send(b, nine, b9, stp);
            xfer(`EUA_OFS_CTL, 1'b0, 32'h0);
            `CHK("rx_done", exp, d[`EUA_CTL_RXDONE])
            if (exp)
            begin
                xfer(`EUA_OFS_BUF, 1'b0, 32'h0);
                `CHK("rx_byte", b, d[7:0])
                xfer(`EUA_OFS_CTL, 1'b1, ctl_v);
            end
        end
    endtask
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        repeat (60000) @(posedge clk);
        errors = errors + 1;
        test_done;
    end
    initial
    begin
        {rst_n, hsel, haddr, htrans, hwrite, hwdata} = 0;
        hsize = 3'h2;
        errors = 0;
        checks = 0;
        seed = 32'hB659;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 7; i = i + 1)
        begin
            xfer(i * 4, 1'b0, 32'h0);
            `CHK("reset", (i == 5) ? {16'h0, `EUA_BAUD_RST} : 32'h0, d)
        end
        xfer(`EUA_OFS_BAUD, 1'b1, 32'h1);
        for (i = 0; i < 3; i = i + 1)
        begin
            // The middle pass runs mode 2 with the ninth transmit bit set.
            ctl_v = (i == 1) ? 32'h98 : 32'h50;
            xfer(`EUA_OFS_CTL, 1'b1, ctl_v);
            seed = lfsr(seed);
            c = cnt;
            xfer(`EUA_OFS_BUF, 1'b1, seed);
            for (n = 0; cnt == c && n < 2000; n = n + 1)
                @(posedge clk);
            `CHK("tx_byte", {c + 8'h01, seed[7:0]}, {cnt, got})
            if (cnt == c)
                test_done;
            d = 32'h0;
            for (n = 0; d[`EUA_CTL_TXDONE] !== 1'b1 && n < 40; n = n + 1)
                xfer(`EUA_OFS_CTL, 1'b0, 32'h0);
            `CHK("tx_done", 1'b1, d[`EUA_CTL_TXDONE])
            if (d[`EUA_CTL_TXDONE] !== 1'b1)
                test_done;
            xfer(`EUA_OFS_CTL, 1'b1, ctl_v);
            rx_check(seed[15:8], i == 1, 1'b0, 1'b1, 1'b1);
        end
        xfer(`EUA_OFS_POWER_CONTROL, 1'b1, 32'h40);
        u_eua_peer.send(8'h3C, 1'b0, 1'b0, 1'b0);
        xfer(`EUA_OFS_CTL, 1'b0, 32'h0);
        `CHK("fe_set", 1'b1, d[7])
        ctl_v = 32'hD0;
        xfer(`EUA_OFS_CTL, 1'b1, ctl_v);
        rx_check(8'hC3, 1'b0, 1'b0, 1'b1, 1'b1);
        xfer(`EUA_OFS_CTL, 1'b0, 32'h0);
        `CHK("fe_hold", 1'b1, d[7])
        xfer(`EUA_OFS_CTL, 1'b1, 32'h50);
        xfer(`EUA_OFS_CTL, 1'b0, 32'h0);
        `CHK("fe_clear", 1'b0, d[7])
        xfer(`EUA_OFS_POWER_CONTROL, 1'b1, 32'h0);
        xfer(`EUA_OFS_SLAVE_ADDRESS, 1'b1, 32'hF1);
        xfer(`EUA_OFS_SMASK, 1'b1, 32'hFA);
        ctl_v = 32'hF0;
        xfer(`EUA_OFS_CTL, 1'b1, ctl_v);
        for (i = 0; i < 8; i = i + 1)
        begin
            seed = lfsr(seed);
            a = (i < 6) ? 48'hF0F4F2FF00F1 >> (8 * i) : seed[7:0];
            rx_check(a, 1'b1, i != 5 && (i < 6 || seed[8]), 1'b1,
                hit(a, 8'hF1, 8'hFA) && i != 5 && (i < 6 || seed[8]));
        end
        ctl_v = 32'hD0;
        xfer(`EUA_OFS_CTL, 1'b1, ctl_v);
        rx_check(8'h5A, 1'b1, 1'b0, 1'b1, 1'b1);
        ctl_v = 32'h70;
        xfer(`EUA_OFS_CTL, 1'b1, ctl_v);
        rx_check(8'hF0, 1'b0, 1'b0, 1'b0, 1'b0);
        rx_check(8'hF0, 1'b0, 1'b0, 1'b1, 1'b1);
        // Mode 0 last: the peer takes its shift clock for frames.
        ctl_v = 32'h0;
        xfer(`EUA_OFS_CTL, 1'b1, ctl_v);
        xfer(`EUA_OFS_BUF, 1'b1, 32'hA5);
        repeat (100) @(posedge clk);
        `CHK("m0_oe", 1'b1, rxd_oe)
        repeat (200) @(posedge clk);
        `CHK("m0_tx", 8'hA5, m0_sh)
        `CHK("m0_oe_off", 1'b0, rxd_oe)
        xfer(`EUA_OFS_CTL, 1'b0, 32'h0);
        `CHK("m0_wait", 2'h2, d[1:0])
        ctl_v = 32'h30;
        xfer(`EUA_OFS_CTL, 1'b1, ctl_v);
        repeat (300) @(posedge clk);
        xfer(`EUA_OFS_CTL, 1'b0, 32'h0);
        `CHK("m0_rx", 1'b1, d[`EUA_CTL_RXDONE])
        xfer(`EUA_OFS_BUF, 1'b0, 32'h0);
        `CHK("m0_byte", 8'hFF, d[7:0])
        test_done;
    end
endmodule
